/* File: sfspi_top.sv */
// Serial flash SPI command port with program data FIFO
// Contract
// (R1) Input bits captured on SCK rise; output changes on SCK fall.
// (R2) Select low means active; select high means standby, SCK ignored.
// (R3) Write-protect low makes the status lock bit block status writes.
// (R4) Hold low suspends shifting and transfer progress until hold returns high.
// (R5) Each command begins with a select falling edge.
// (R6) Input assembled into bytes; first byte is the opcode.
// (R7) SCK level at select fall picks mode 0 (low) or 3 (high).
// (R8) Read 03h: three address bytes, then data while clocking continues.
// (R9) Fast read 0Bh: three address bytes, one dummy byte, then data.
// (R10) 20h or D7h with three address bytes starts small-sector erase.
// (R11) D8h with three address bytes starts large-sector erase.
// (R12) 60h or C7h alone starts whole-array erase.
// (R13) 02h with three address bytes then data bytes programs a page.
// (R14) 06h sets write enable; 04h clears it.
// (R15) B9h enters power-down; ABh while powered down leaves it.
// (R16) 05h returns the status byte.
// (R17) 01h plus one byte loads writable status bits.
// (R18) 9Fh returns manufacturer and device identification bytes.
// (R19) No two-bit reads; data pins stay single direction.
// (R20) Address bits 23 to 20 ignored; lower 20 bits used.
// (R21) Read address increments per byte, wrapping top to zero.
// (R22) Select high ends a read; output floats while deselected.
// (R23) Status bit 0 busy, bit 1 write enable, both zero after reset; reset clears bit 1 and bits 7 to 2, bit 0 follows array_busy.
// (R24) Writes without write enable discarded; unknown opcodes ignored till deselect.
// (R25) Select rise mid-byte aborts; next select fall restarts decoding.
`timescale 1ns/1ps

module sfspi_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  wire          push  = in_valid & in_ready;
  wire          pop   = out_valid & out_ready;
  wire [AW:0]   fill  = wp_r - rp_r;

  assign in_ready  = (fill != (AW+1)'(D));
  assign out_valid = (fill != '0);
  assign out_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule // sfspi_fifo

module sfspi_top import sfspi_pkg::*; #(
  parameter logic [7:0] MFR_ID  = 8'h5a, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] CAP_ID  = 8'h14, // Arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h13  // Arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              sck_pin,
  input  wire logic              cs_n_pin,
  input  wire logic              serial_in_pin,
  input  wire logic              wp_n_pin,
  input  wire logic              hold_n_pin,
  output      logic              serial_out_pin,
  output      logic              serial_out_oe,
  output      logic              spi_mode3,
  output      logic              write_enabled,
  output      logic              powered_down,
  output      logic [7:0]        status_byte,
  input  wire logic              array_busy,
  output      logic              rd_req,
  output      logic [ADDR_W-1:0] rd_addr,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_valid,
  output      logic              cmd_valid,
  output      sfspi_cmd_s        cmd,
  output      logic              prog_valid,
  input  wire logic              prog_ready,
  output      logic [7:0]        program_data_byte,
  output      logic              prog_overrun
);

  logic [SYNC_N-1:0] sy1_r;
  logic [SYNC_N-1:0] sy2_r;
  logic              sck_q_r;
  logic              cs_q_r;
  sfspi_state_e      state_r;
  sfspi_state_e      state_nxt;
  logic [7:0]        op_r;
  logic [7:0]        op_nxt;
  logic [2:0]        bit_r;
  logic [7:0]        sh_r;
  logic [1:0]        abyte_r;
  logic [1:0]        abyte_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              wel_r;
  logic              wel_nxt;
  logic              pd_r;
  logic              pd_nxt;
  logic [7:2]        nv_r;
  logic [7:2]        nv_nxt;
  logic              load_r;
  logic              load_nxt;
  logic              cmd_vld_nxt;
  sfspi_cmd_s        cmd_r;
  sfspi_cmd_s        cmd_nxt;
  logic              rd_req_nxt;
  logic              push;
  logic              so_r;
  logic [7:0]        tx_sh_r;
  logic [7:0]        rd_buf_r;
  logic [1:0]        jid_r;
  logic              mode3_r;
  logic              pend_r;
  logic [7:0]        pend_d_r;
  logic              ovr_r;
  logic              f_in_ready;

  // Two-stage synchronisers for all pins
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sy1_r[gi] <= SYNC_RST[gi];
          sy2_r[gi] <= SYNC_RST[gi];
        end else begin
          sy1_r[gi] <= (gi == SY_SCK)  ? sck_pin :
                       (gi == SY_CS)   ? cs_n_pin :
                       (gi == SY_SI)   ? serial_in_pin :
                       (gi == SY_WP)   ? wp_n_pin : hold_n_pin;
          sy2_r[gi] <= sy1_r[gi];
        end
      end
    end
  endgenerate

  wire sck_s    = sy2_r[SY_SCK];
  wire cs_n_s   = sy2_r[SY_CS];
  wire si_s     = sy2_r[SY_SI];
  wire wp_n_s   = sy2_r[SY_WP];
  wire hold_n_s = sy2_r[SY_HOLD];

  // Select framing and SCK edges
  wire cs_fall = cs_q_r & ~cs_n_s;
  wire cs_rise = ~cs_q_r & cs_n_s;
  // (R2) (R4) Edges only while selected and not held
  wire active  = ~cs_n_s & hold_n_s & ~cs_fall;
  wire sck_up  = active & sck_s & ~sck_q_r;
  wire sck_dn  = active & ~sck_s & sck_q_r;
  // (R6) Byte completion on eighth rise
  wire       byte_done = sck_up & (bit_r == 3'h7);
  wire [7:0] byte_in   = {sh_r[6:0], si_s};
  // (R20) Upper address nibble dropped
  wire [ADDR_W-1:0] addr_full = {addr_r[11:0], byte_in};

  // (R3) Lock effective only with write-protect low
  wire lock_eff = nv_r[STAT_LOCK] & ~wp_n_s;
  // (R23) Status byte composition
  wire [7:0] status_w = {nv_r, wel_r, array_busy};

  wire is_read  = (op_r == OP_READ) | (op_r == OP_FAST);
  wire [7:0] jid_byte = (jid_r == 2'h0) ? MFR_ID : (jid_r == 2'h1) ? TYPE_ID : CAP_ID;
  wire [7:0] tx_byte  = (op_r == OP_RDSR) ? status_w :
                        (op_r == OP_JID)  ? jid_byte :
                        (op_r == OP_ID)   ? DEV_ID : rd_buf_r;

  always_comb begin
    state_nxt   = state_r;
    op_nxt      = op_r;
    abyte_nxt   = abyte_r;
    addr_nxt    = addr_r;
    wel_nxt     = wel_r;
    pd_nxt      = pd_r;
    nv_nxt      = nv_r;
    load_nxt    = load_r;
    cmd_vld_nxt = 1'b0;
    cmd_nxt     = cmd_r;
    rd_req_nxt  = 1'b0;
    push        = 1'b0;
    // (R22) (R25) Deselect returns to idle; a page program in data phase ends with CMD_PP_END
    if (cs_rise) begin
      state_nxt = ST_IDLE;
      load_nxt  = 1'b0;
      if (op_r == OP_PP && state_r == ST_WDATA) begin
        cmd_vld_nxt  = 1'b1;
        cmd_nxt.kind = CMD_PP_END;
      end
    // (R5) Select fall opens a new command
    end else if (cs_fall) begin
      state_nxt = ST_IDLE;
      load_nxt  = 1'b0;
    end else begin
      // (R1) Byte loaded at this fall
      if (sck_dn && load_r) begin
        load_nxt = 1'b0;
      end
      if (byte_done) begin
        unique case (state_r)
          ST_IDLE: begin
            op_nxt    = byte_in;
            abyte_nxt = 2'h0;
            // (R24) Unknown or refused opcodes skip to deselect
            state_nxt = ST_SKIP;
            if (pd_r) begin
              // (R15) Only wake-up honoured in power-down
              if (byte_in == OP_ID) begin
                pd_nxt = 1'b0;
              end
            end else begin
              case (byte_in)
                // (R8) (R9) (R10) (R11) (R13) Address phase
                OP_READ, OP_FAST, OP_ID: state_nxt = ST_ADDR;
                OP_SSE_A, OP_SSE_B, OP_SE, OP_PP: begin
                  if (wel_r) begin
                    state_nxt = ST_ADDR;
                  end
                end
                // (R12) Whole-array erase
                OP_CE_A, OP_CE_B: begin
                  if (wel_r) begin
                    cmd_vld_nxt = 1'b1;
                    cmd_nxt     = '{kind: CMD_CE, addr: ADDR_RST};
                    wel_nxt     = 1'b0;
                  end
                end
                // (R14) Write enable latch
                OP_WREN: wel_nxt = 1'b1;
                OP_WRDI: wel_nxt = 1'b0;
                // (R15) Enter power-down
                OP_PD: pd_nxt = 1'b1;
                // (R16) (R18) Immediate output
                OP_RDSR, OP_JID: begin
                  state_nxt = ST_OUT;
                  load_nxt  = 1'b1;
                end
                // (R17) Status data byte follows
                OP_WRSR: begin
                  if (wel_r) begin
                    state_nxt = ST_WDATA;
                  end
                end
                default: state_nxt = ST_SKIP;
              endcase
            end
          end
          ST_ADDR: begin
            addr_nxt  = addr_full;
            abyte_nxt = abyte_r + 2'h1;
            if (abyte_r == ADDR_LAST) begin
              unique case (1'b1)
                (op_r == OP_READ): begin
                  state_nxt  = ST_OUT;
                  load_nxt   = 1'b1;
                  rd_req_nxt = 1'b1;
                end
                (op_r == OP_FAST): begin
                  state_nxt  = ST_DUMMY;
                  rd_req_nxt = 1'b1;
                end
                (op_r == OP_ID): begin
                  state_nxt = ST_OUT;
                  load_nxt  = 1'b1;
                end
                (op_r == OP_PP): begin
                  state_nxt   = ST_WDATA;
                  cmd_vld_nxt = 1'b1;
                  cmd_nxt     = '{kind: CMD_PP_START, addr: addr_full};
                  wel_nxt     = 1'b0;
                end
                default: begin
                  state_nxt   = ST_SKIP;
                  cmd_vld_nxt = 1'b1;
                  cmd_nxt     = '{kind: (op_r == OP_SE) ? CMD_SE : CMD_SSE, addr: addr_full};
                  wel_nxt     = 1'b0;
                end
              endcase
            end
          end
          // (R9) Dummy byte before data
          ST_DUMMY: begin
            state_nxt = ST_OUT;
            load_nxt  = 1'b1;
          end
          // (R21) Prefetch next read byte with wrap
          ST_OUT: begin
            load_nxt = 1'b1;
            if (is_read) begin
              addr_nxt   = addr_r + ADDR_ONE;
              rd_req_nxt = 1'b1;
            end
          end
          ST_WDATA: begin
            if (op_r == OP_WRSR) begin
              state_nxt = ST_SKIP;
              // (R3) (R17) Guarded status load
              if (!lock_eff) begin
                nv_nxt       = byte_in[7:2];
                wel_nxt      = 1'b0;
                cmd_vld_nxt  = 1'b1;
                cmd_nxt.kind = CMD_SRW;
              end
            end else begin
              // (R13) Program data into FIFO
              push = 1'b1;
            end
          end
          ST_SKIP: state_nxt = ST_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q_r <= 1'b0;
      cs_q_r  <= 1'b1;
      state_r <= ST_IDLE;
      op_r    <= 8'h00;
      abyte_r <= 2'h0;
      addr_r  <= ADDR_RST;
      load_r  <= 1'b0;
      cmd_r   <= '{kind: CMD_NONE, addr: ADDR_RST};
      rd_req  <= 1'b0;
      cmd_valid <= 1'b0;
    end else begin
      sck_q_r <= sck_s;
      cs_q_r  <= cs_n_s;
      state_r <= state_nxt;
      op_r    <= op_nxt;
      abyte_r <= abyte_nxt;
      addr_r  <= addr_nxt;
      load_r  <= load_nxt;
      cmd_r   <= cmd_nxt;
      rd_req  <= rd_req_nxt;
      cmd_valid <= cmd_vld_nxt;
    end
  end

  // (R23) Volatile bits cleared at reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wel_r <= 1'b0;
      pd_r  <= 1'b0;
      nv_r  <= STAT_NV_RST;
    end else begin
      wel_r <= wel_nxt;
      pd_r  <= pd_nxt;
      nv_r  <= nv_nxt;
    end
  end

  // (R1) (R6) (R25) Input shifter on SCK rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_r <= 3'h0;
      sh_r  <= 8'h00;
    end else if (cs_fall || cs_rise) begin
      bit_r <= 3'h0;
    end else if (sck_up) begin
      bit_r <= bit_r + 3'h1;
      sh_r  <= byte_in;
    end
  end

  // (R7) Mode captured at select fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode3_r <= 1'b0;
    end else if (cs_fall) begin
      mode3_r <= sck_s;
    end
  end

  // (R1) Output shifter on SCK fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_r    <= 1'b0;
      tx_sh_r <= 8'h00;
      jid_r   <= 2'h0;
    end else if (cs_fall) begin
      jid_r <= 2'h0;
    end else if (sck_dn && load_r) begin
      so_r    <= tx_byte[7];
      tx_sh_r <= {tx_byte[6:0], 1'b0};
      jid_r   <= (jid_r == JID_LAST) ? 2'h0 : jid_r + 2'h1;
    end else if (sck_dn) begin
      so_r    <= tx_sh_r[7];
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_buf_r <= 8'h00;
    end else if (rd_valid) begin
      rd_buf_r <= rd_data;
    end
  end

  // Pending program byte waits for FIFO space
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r   <= 1'b0;
      pend_d_r <= 8'h00;
      ovr_r    <= 1'b0;
    end else begin
      if (push) begin
        pend_r   <= 1'b1;
        pend_d_r <= byte_in;
      end else if (f_in_ready) begin
        pend_r <= 1'b0;
      end
      if (push && pend_r && !f_in_ready) begin
        ovr_r <= 1'b1;
      end else if (cs_fall) begin
        ovr_r <= 1'b0;
      end
    end
  end

  sfspi_fifo #(
    .W (BYTE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pend_r),
    .in_ready  (f_in_ready),
    .in_data   (pend_d_r),
    .out_valid (prog_valid),
    .out_ready (prog_ready),
    .out_data  (program_data_byte)
  );

  // (R19) (R22) (R4) Output driven only when selected and not held
  assign serial_out_oe  = ~cs_n_s & hold_n_s;
  assign serial_out_pin = so_r;
  assign spi_mode3      = mode3_r;
  assign write_enabled  = wel_r;
  assign powered_down   = pd_r;
  assign status_byte    = status_w;
  assign rd_addr        = addr_r;
  assign cmd            = cmd_r;
  assign prog_overrun   = ovr_r;

endmodule // sfspi_top

/* File: sfspi_pkg.sv */
// Shared constants and types of the serial flash command port
package sfspi_pkg;

  localparam int BYTE_W     = 8;
  localparam int ADDR_W     = 20;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_N     = 5;

  // Synchroniser lanes and their reset levels
  localparam int SY_SCK  = 0;
  localparam int SY_CS   = 1;
  localparam int SY_SI   = 2;
  localparam int SY_WP   = 3;
  localparam int SY_HOLD = 4;
  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h1a;

  // Opcodes
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FAST  = 8'h0b;
  localparam logic [7:0] OP_SSE_A = 8'h20;
  localparam logic [7:0] OP_SSE_B = 8'hd7;
  localparam logic [7:0] OP_SE    = 8'hd8;
  localparam logic [7:0] OP_CE_A  = 8'h60;
  localparam logic [7:0] OP_CE_B  = 8'hc7;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_PD    = 8'hb9;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_JID   = 8'h9f;
  localparam logic [7:0] OP_ID    = 8'hab;

  // Address handling and identification byte count
  localparam logic [1:0]        ADDR_LAST = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 20'h0_0001;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h0_0000;
  localparam logic [1:0]        JID_LAST  = 2'h2;

  // Status byte layout and reset values
  localparam int         STAT_BUSY = 0;
  localparam int         STAT_WEL  = 1;
  localparam int         STAT_LOCK = 7;
  localparam logic [7:2] STAT_NV_RST = 6'h00;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_ADDR  = 6'b00_0010,
    ST_DUMMY = 6'b00_0100,
    ST_OUT   = 6'b00_1000,
    ST_WDATA = 6'b01_0000,
    ST_SKIP  = 6'b10_0000
  } sfspi_state_e;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_SSE      = 3'h1,
    CMD_SE       = 3'h2,
    CMD_CE       = 3'h3,
    CMD_PP_START = 3'h4,
    CMD_PP_END   = 3'h5,
    CMD_SRW      = 3'h6
  } sfspi_cmd_e;

  typedef struct packed {
    sfspi_cmd_e        kind;
    logic [ADDR_W-1:0] addr;
  } sfspi_cmd_s;

endpackage

/* File: sfspi_host.sv */
// SPI host model driving the serial flash command port
`timescale 1ns/1ps

module sfspi_host (
  input  wire logic clk,
  input  wire logic so,
  output      logic sck,
  output      logic cs_n,
  output      logic si
);
  logic m3_r;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
    m3_r = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start(input logic m3);
    m3_r = m3;
    sck  = m3;
    cs_n = 1'b0;
    wt(4);
  endtask

  task automatic bits(input logic [7:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si  = d[i];
      wt(4);
      sck = 1'b1;
      wt(4);
      rx = {rx[6:0], so};
    end
  endtask

  task automatic stop();
    sck = m3_r;
    wt(4);
    cs_n = 1'b1;
    si   = ~si;
    wt(4);
  endtask
endmodule // sfspi_host

/* File: sfspi_top_chk.sv */
// Concurrent checks on the serial flash command port
`timescale 1ns/1ps

module sfspi_top_chk import sfspi_pkg::*; (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              sck_pin,
  input wire logic              cs_n_pin,
  input wire logic              hold_n_pin,
  input wire logic              serial_out_oe,
  input wire logic              spi_mode3,
  input wire logic              write_enabled,
  input wire logic [7:0]        status_byte,
  input wire logic              array_busy,
  input wire logic              rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic              cmd_valid,
  input wire sfspi_cmd_s        cmd,
  input wire logic              prog_valid,
  input wire logic              prog_ready,
  input wire logic [7:0]        program_data_byte
);
  logic [ADDR_W-1:0] last_addr_r;
  logic              in_read_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Address of the previous request in this frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_addr_r <= ADDR_RST;
      in_read_r   <= 1'b0;
    end else begin
      if (rd_req) last_addr_r <= rd_addr;
      in_read_r <= (in_read_r | rd_req) & !cs_n_pin;
    end
  end

  oe_desel_a: assert property (cs_n_pin [*3] |-> !serial_out_oe)
    else $error("output enabled while deselected");
  oe_hold_a: assert property (!hold_n_pin [*3] |-> !serial_out_oe)
    else $error("output enabled during hold");
  mode_three_a: assert property ($fell(cs_n_pin) && sck_pin |-> ##[1:6] spi_mode3)
    else $error("mode 3 not taken");
  mode_zero_a: assert property ($fell(cs_n_pin) && !sck_pin |-> ##[1:6] !spi_mode3)
    else $error("mode 0 not taken");
  rd_step_a: assert property (rd_req && in_read_r |-> rd_addr == last_addr_r + ADDR_ONE)
    else $error("read address did not step");
  rd_pulse_a: assert property (rd_req |=> !rd_req [*8])
    else $error("read requests too close");
  wel_guard_a: assert property (cmd_valid && cmd.kind != CMD_PP_END |-> $past(write_enabled, 2))
    else $error("write command without write enable");
  status_reset_a: assert property ($rose(rstn) |-> status_byte[7:1] == {STAT_NV_RST, 1'b0})
    else $error("status not cleared by reset");
  prog_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(program_data_byte))
    else $error("program byte dropped while stalled");
endmodule // sfspi_top_chk

bind sfspi_top sfspi_top_chk i_chk (.clk(clk), .rstn(rstn), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin),
  .hold_n_pin(hold_n_pin), .serial_out_oe(serial_out_oe), .spi_mode3(spi_mode3),
  .write_enabled(write_enabled), .status_byte(status_byte), .array_busy(array_busy), .rd_req(rd_req),
  .rd_addr(rd_addr), .cmd_valid(cmd_valid), .cmd(cmd), .prog_valid(prog_valid), .prog_ready(prog_ready),
  .program_data_byte(program_data_byte));

/* File: sfspi_top_bench.sv */
// Testbench of the serial flash command port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  n_compared++; \
  if ((gt) !== (ex)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
  end \
end

module sfspi_top_bench import sfspi_pkg::*;;
  logic clk = 1'b0;
  logic rstn, wp_n, hold_n, busy, rd_valid, prog_ready, wel_m;
  logic [7:0] rd_data, r;
  logic [5:0] nv_m;
  logic [23:0] a, d;
  wire logic sck, cs_n, si, so, oe, mode3, wel, pd, rd_req, cmd_valid, prog_valid, ovr;
  wire logic so_line = oe ? so : 1'bz;
  wire logic [7:0] status_byte, prog_byte;
  wire logic [ADDR_W-1:0] rd_addr;
  sfspi_cmd_s cmd;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h3563_4452;
  logic [7:0] rxq[$];
  logic [7:0] progq[$];
  sfspi_cmd_s cmdq[$];
  logic [7:0] eops[5] = '{OP_SSE_A, OP_SSE_B, OP_SE, OP_CE_A, OP_CE_B};
  sfspi_cmd_e ekind[5] = '{CMD_SSE, CMD_SSE, CMD_SE, CMD_CE, CMD_CE};

  always #25 clk = ~clk;

  sfspi_top i_dut (.clk(clk), .rstn(rstn), .sck_pin(sck), .cs_n_pin(cs_n), .serial_in_pin(si),
    .wp_n_pin(wp_n), .hold_n_pin(hold_n), .serial_out_pin(so), .serial_out_oe(oe), .spi_mode3(mode3),
    .write_enabled(wel), .powered_down(pd), .status_byte(status_byte), .array_busy(busy),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_valid(cmd_valid),
    .cmd(cmd), .prog_valid(prog_valid), .prog_ready(prog_ready), .program_data_byte(prog_byte),
    .prog_overrun(ovr));

  sfspi_host i_host (.clk(clk), .so(so_line), .sck(sck), .cs_n(cs_n), .si(si));

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] pat(input logic [19:0] ad);
    return ad[7:0] + ad[19:12] + 8'h11;
  endfunction

  // Array answers and random stall of program bytes
  always @(negedge clk) begin
    rd_valid   <= rd_req;
    rd_data    <= pat(rd_addr);
    prog_ready <= rnd8() > 8'h60;
  end

  always @(posedge clk) begin
    if (cmd_valid) cmdq.push_back(cmd);
    if (prog_valid && prog_ready) progq.push_back(prog_byte);
  end

  task automatic xact(input logic m3, input logic [7:0] tx[$], input int nrd);
    rxq = {};
    i_host.start(m3);
    foreach (tx[i]) i_host.bits(tx[i], 8, r);
    repeat (nrd) begin
      i_host.bits(rnd8(), 8, r);
      rxq.push_back(r);
    end
    i_host.stop();
  endtask

  task automatic chk_sr();
    busy = rnd8() > 8'h80;
    xact(1'b0, '{OP_RDSR}, 2);
    `CHK("status", {nv_m, wel_m, busy}, rxq[0])
    `CHK("status repeat", {nv_m, wel_m, busy}, rxq[1])
    `CHK("wel", wel_m, wel)
    `CHK("status port", {nv_m, wel_m, busy}, status_byte)
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    errors++;
    test_done();
  end

  initial begin
    {rstn, wp_n, hold_n, busy} = 4'b0110;
    wel_m = 1'b0;
    nv_m  = 6'h00;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("oe idle", 1'b0, oe)
    chk_sr();
    // Aborted and held bytes
    i_host.start(1'b0);
    i_host.bits(OP_WREN, 7, r);
    i_host.stop();
    `CHK("wel after abort", 1'b0, wel)
    i_host.start(1'b0);
    i_host.bits(8'h00, 4, r);
    hold_n = 1'b0;
    i_host.bits(8'hff, 4, r);
    hold_n = 1'b1;
    i_host.bits(8'h60, 4, r);
    i_host.stop();
    wel_m = 1'b1;
    chk_sr();
    xact(1'b1, '{OP_WRDI}, 0);
    wel_m = 1'b0;
    chk_sr();
    xact(1'b0, '{OP_SSE_A, 8'h01, 8'h23, 8'h45}, 0);
    `CHK("refused erase", 0, cmdq.size())
    $display("test status and framing done");
    for (int k = 0; k < 5; k++) begin
      a = {rnd8(), rnd8(), rnd8()};
      cmdq = {};
      xact(1'b0, '{OP_WREN}, 0);
      if (k > 2) xact(1'b1, '{eops[k]}, 0);
      else xact(1'b1, '{eops[k], a[23:16], a[15:8], a[7:0]}, 0);
      `CHK("erase count", 1, cmdq.size())
      `CHK("erase kind", ekind[k], cmdq[0].kind)
      if (k < 3) `CHK("erase addr", a[19:0], cmdq[0].addr)
    end
    $display("test erase done");
    a = {rnd8(), rnd8(), rnd8()};
    d = {rnd8(), rnd8(), rnd8()};
    cmdq = {};
    xact(1'b0, '{OP_WREN}, 0);
    xact(1'b0, '{OP_PP, a[23:16], a[15:8], a[7:0], d[23:16], d[15:8], d[7:0]}, 0);
    for (int w = 0; w < 60 && progq.size() < 3; w++) @(negedge clk);
    `CHK("prog count", 3, progq.size())
    for (int i = 0; i < 3; i++) `CHK("prog byte", d[23-8*i -: 8], progq[i])
    `CHK("prog start", CMD_PP_START, cmdq[0].kind)
    `CHK("prog addr", a[19:0], cmdq[0].addr)
    `CHK("prog end", CMD_PP_END, cmdq[1].kind)
    `CHK("overrun", 1'b0, ovr)
    $display("test program done");
    xact(1'b0, '{OP_WREN}, 0);
    xact(1'b0, '{OP_WRSR, 8'h9c}, 0);
    nv_m = 6'h27;
    chk_sr();
    wp_n = 1'b0;
    xact(1'b0, '{OP_WREN}, 0);
    xact(1'b0, '{OP_WRSR, 8'h00}, 0);
    wel_m = 1'b1;
    chk_sr();
    wp_n = 1'b1;
    xact(1'b0, '{OP_PD}, 0);
    `CHK("power down", 1'b1, pd)
    xact(1'b0, '{OP_WRDI}, 0);
    xact(1'b0, '{OP_ID}, 0);
    `CHK("wake", 1'b0, pd)
    chk_sr();
    $display("test status write and power down done");
    xact(1'b1, '{OP_READ, 8'haf, 8'hff, 8'hfe}, 3);
    `CHK("mode 3", 1'b1, mode3)
    for (int i = 0; i < 3; i++) `CHK("read wrap", pat(20'hf_fffe + i), rxq[i])
    a = {rnd8(), rnd8(), rnd8()};
    xact(1'b0, '{OP_FAST, a[23:16], a[15:8], a[7:0], rnd8()}, 2);
    `CHK("mode 0", 1'b0, mode3)
    for (int i = 0; i < 2; i++) `CHK("fast read", pat(a[19:0] + i), rxq[i])
    xact(1'b0, '{OP_JID}, 3);
    `CHK("id maker", 8'h5a, rxq[0])
    `CHK("id type", 8'h3c, rxq[1])
    `CHK("id size", 8'h14, rxq[2])
    xact(1'b1, '{OP_ID, 8'h00, 8'h00, 8'h00}, 1);
    `CHK("device id", 8'h13, rxq[0])
    $display("test reads done");
    test_done();
  end
endmodule // sfspi_top_bench
